// file: core/sdc_command_bank.sv
// command word bank: object access port and drive control outputs
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdc_command_bank (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        clkEn,
	// object access port
	input  wire logic        objWrEn,
	input  wire logic        objRdEn,
	input  wire logic [15:0] objIndex,
	input  wire logic [15:0] objWrData,
	output logic      [15:0] objRdData,
	output logic             objRdValid,
	output logic             objErr,
	// drive state machine permission
	input  wire logic        modeChangeOk,
	// word A controls
	output logic             bridgeDisable,
	output logic             zeroPosError,
	output logic             phaseDetect,
	output logic             setPosition,
	output logic             loadAuxCounter,
	output logic             homeExecute,
	output logic             cmdStop,
	output logic      [2:0]  captureArm,
	output logic      [2:0]  captureDisarm,
	output logic             posLimit,
	output logic             negLimit,
	output logic             clearEvents,
	// word B controls
	output logic             gainSet,
	output logic             limiterSet,
	output logic             modifierSet,
	output logic             jogPlus,
	output logic             jogMinus,
	output logic      [1:0]  jogSpeed,
	// other objects
	output logic      [15:0] userOut,
	output logic      [7:0]  reqMode,
	output logic      [7:0]  actualMode,
	output logic      [15:0] currentDemand
);

	//------------------------------------------------------------------
	// state and decode
	//------------------------------------------------------------------

	sdc_pkg::sdc_state_t st;
	sdc_pkg::sdc_state_t next_st;

	logic        wrA;
	logic        wrB;
	logic        wrUser;
	logic        wrReq;
	logic        wrCur;
	logic        knownIdx;
	logic        readOnlyIdx;
	logic [15:0] newA;
	logic [15:0] newB;
	logic [2:0]  capRise;
	logic [2:0]  capFall;
	logic [2:0]  setRise;
	logic [2:0]  setFall;

	// index decode of a write
	always_comb begin
		wrA         = objWrEn && (objIndex == `SDC_IDX_CMD_A);
		wrB         = objWrEn && (objIndex == `SDC_IDX_CMD_B);
		wrUser      = objWrEn && (objIndex == `SDC_IDX_USER);
		wrReq       = objWrEn && (objIndex == `SDC_IDX_REQ_MODE);
		wrCur       = objWrEn && (objIndex == `SDC_IDX_TARGET_CUR);
		readOnlyIdx = (objIndex == `SDC_IDX_ACT_MODE);
		knownIdx    = (objIndex == `SDC_IDX_CMD_A) ||
		              (objIndex == `SDC_IDX_CMD_B) ||
		              (objIndex == `SDC_IDX_USER) ||
		              (objIndex == `SDC_IDX_REQ_MODE) ||
		              (objIndex == `SDC_IDX_TARGET_CUR) ||
		              readOnlyIdx;
	end

	// reserved bits never reach storage, so they always read zero
	assign newA = objWrData & `SDC_MASK_CMD_A; // RULE10 RULE20
	assign newB = objWrData & `SDC_MASK_CMD_B; // RULE10

	//------------------------------------------------------------------
	// edge detection against the stored words
	//------------------------------------------------------------------

	// capture units arm on rise, disarm on fall
	sdc_edge_det #(
		.W (3)
	) uCaptureEdge (
		.prevBits (st.cmdA[`SDC_A_CAPTURE_HI:`SDC_A_CAPTURE_LO]),
		.newBits  (newA[`SDC_A_CAPTURE_HI:`SDC_A_CAPTURE_LO]),
		.wrStrobe (wrA),
		.rise     (capRise),
		.fall     (capFall)
	);

	// parameter set selects change only on edges
	sdc_edge_det #(
		.W (3)
	) uSetEdge (
		.prevBits (st.cmdB[`SDC_B_SET_HI:`SDC_B_SET_LO]),
		.newBits  (newB[`SDC_B_SET_HI:`SDC_B_SET_LO]),
		.wrStrobe (wrB),
		.rise     (setRise),
		.fall     (setFall)
	);

	//------------------------------------------------------------------
	// next state
	//------------------------------------------------------------------

	// stores, edge actions, mode switch and read answer
	always_comb begin
		next_st               = st;
		next_st.captureArm    = capRise; // RULE8
		next_st.captureDisarm = capFall; // RULE8
		next_st.rdValid       = 1'b0;
		next_st.accErr        = 1'b0;

		if (wrA) begin
			next_st.cmdA = newA; // RULE20
		end
		if (wrB) begin
			next_st.cmdB = newB;
		end
		if (wrUser) begin
			next_st.userBits = objWrData; // RULE16
		end
		if (wrReq) begin
			next_st.reqMode = objWrData[7:0]; // RULE17
		end
		if (wrCur) begin
			next_st.targetCur = objWrData; // RULE19
		end

		// clear wins; an edge in each direction at once cannot happen
		next_st.setSelect = (st.setSelect | setRise) & ~setFall; // RULE11 RULE12 RULE13

		// actual mode follows request only with permission
		if (modeChangeOk && (st.reqMode != st.actMode)) begin
			next_st.actMode = st.reqMode; // RULE17
		end

		// demand is zero outside current mode
		if (next_st.actMode == `SDC_MODE_CURRENT) begin // RULE18
			next_st.currentDemand = next_st.targetCur; // RULE19
		end else begin
			next_st.currentDemand = 16'h0000; // RULE19
		end

		// writes to unknown or read-only objects are flagged
		if (objWrEn && (!knownIdx || readOnlyIdx)) begin
			next_st.accErr = 1'b1;
		end

		// read answer one cycle after the request
		if (objRdEn) begin
			next_st.rdValid = 1'b1;
			case (objIndex)
				`SDC_IDX_CMD_A: begin
					next_st.rdData = st.cmdA; // RULE10
				end
				`SDC_IDX_CMD_B: begin
					next_st.rdData = st.cmdB; // RULE10
				end
				`SDC_IDX_USER: begin
					next_st.rdData = st.userBits;
				end
				`SDC_IDX_REQ_MODE: begin
					next_st.rdData = {8'h00, st.reqMode};
				end
				`SDC_IDX_ACT_MODE: begin
					next_st.rdData = {8'h00, st.actMode}; // RULE17
				end
				`SDC_IDX_TARGET_CUR: begin
					next_st.rdData = st.targetCur;
				end
				default: begin
					next_st.rdData = 16'h0000;
					next_st.accErr = 1'b1;
				end
			endcase
		end
	end

	// one register for the whole bank; enable freezes it
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st               <= '0;
			st.cmdA          <= `SDC_RST_WORD;
			st.cmdB          <= `SDC_RST_WORD;
			st.userBits      <= `SDC_RST_WORD;
			st.reqMode       <= `SDC_RST_MODE;
			st.actMode       <= `SDC_RST_MODE;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	//------------------------------------------------------------------
	// outputs, all straight from the state register
	//------------------------------------------------------------------

	// word A levels go out as stored; the drive acts while they hold
	assign bridgeDisable  = st.cmdA[`SDC_A_BRIDGE_OFF];   // RULE1
	assign zeroPosError   = st.cmdA[`SDC_A_ZERO_PERR];    // RULE2
	assign phaseDetect    = st.cmdA[`SDC_A_PHASE_DET];    // RULE3
	assign setPosition    = st.cmdA[`SDC_A_SET_POS];      // RULE4
	assign loadAuxCounter = st.cmdA[`SDC_A_LOAD_AUX];     // RULE5
	assign homeExecute    = st.cmdA[`SDC_A_HOME_EXEC];    // RULE6
	assign cmdStop        = st.cmdA[`SDC_A_STOP];         // RULE7
	assign posLimit       = st.cmdA[`SDC_A_POS_LIMIT];
	assign negLimit       = st.cmdA[`SDC_A_NEG_LIMIT];
	assign clearEvents    = st.cmdA[`SDC_A_CLEAR_EVENTS]; // RULE9
	assign captureArm     = st.captureArm;
	assign captureDisarm  = st.captureDisarm;

	// word B: set selects from edge state, jog bits as levels
	assign gainSet     = st.setSelect[0];
	assign limiterSet  = st.setSelect[1];
	assign modifierSet = st.setSelect[2];
	assign jogPlus     = st.cmdB[`SDC_B_JOG_PLUS];  // RULE14
	assign jogMinus    = st.cmdB[`SDC_B_JOG_MINUS]; // RULE14
	assign jogSpeed    = st.cmdB[`SDC_B_JOG_SPD_HI:`SDC_B_JOG_SPD_LO]; // RULE15

	// remaining objects and the access answer
	assign userOut       = st.userBits; // RULE16
	assign reqMode       = st.reqMode;
	assign actualMode    = st.actMode;
	assign currentDemand = st.currentDemand;
	assign objRdData     = st.rdData;
	assign objRdValid    = st.rdValid;
	assign objErr        = st.accErr;

	//------------------------------------------------------------------
	// assertions
	//------------------------------------------------------------------

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// reserved bits can never be stored
	AST_RESERVED_ZERO: assert property ( // RULE10
		st.cmdA[15:13] == 3'b000 && st.cmdB[15:7] == 9'h000
	) else $error("reserved command bits hold a one");

	// a write of bit 0 disables the bridge next cycle
	AST_BRIDGE_OFF: assert property ( // RULE1
		clkEn && wrA && objWrData[0] |=> bridgeDisable
	) else $error("bridge not disabled after write");

	// event clear follows the written bit
	AST_CLEAR_EVENTS: assert property ( // RULE9
		clkEn && wrA |=> clearEvents == $past(objWrData[12])
	) else $error("event clear does not follow write");

	// capture arm pulses on a rise only, for one cycle
	AST_CAPTURE_ARM: assert property ( // RULE8
		clkEn && wrA && objWrData[7] && !st.cmdA[7]
		|=> captureArm[0] ##1 (!captureArm[0] || $past(clkEn) == 1'b0
		    || $past(wrA))
	) else $error("capture 1 arm pulse wrong");

	// a fall disarms and never arms
	AST_CAPTURE_DISARM: assert property ( // RULE8
		clkEn && wrA && !objWrData[8] && st.cmdA[8]
		|=> captureDisarm[1] && !captureArm[1]
	) else $error("capture 2 disarm missing");

	// rewriting the same value gives no edge
	AST_NO_EDGE_SAME: assert property ( // RULE21
		clkEn && wrA && (newA[9:7] == st.cmdA[9:7])
		|=> captureArm == 3'b000 && captureDisarm == 3'b000
	) else $error("edge seen without a change");

	// gain set follows a rise of bit 0
	AST_GAIN_RISE: assert property ( // RULE11
		clkEn && wrB && objWrData[0] && !st.cmdB[0] |=> gainSet
	) else $error("gain set 1 not selected");

	// limiter set returns to 0 on a fall
	AST_LIMITER_FALL: assert property ( // RULE12
		clkEn && wrB && !objWrData[1] && st.cmdB[1] |=> !limiterSet
	) else $error("limiter set 0 not selected");

	// modifier set holds when no write arrives
	AST_MODIFIER_HOLD: assert property ( // RULE13
		!wrB |=> $stable(modifierSet)
	) else $error("modifier set moved without a write");

	// jog levels and speed track the written word
	AST_JOG_LEVELS: assert property ( // RULE14
		clkEn && wrB
		|=> jogPlus == $past(objWrData[3]) && jogMinus == $past(objWrData[4])
	) else $error("jog levels wrong");

	AST_JOG_SPEED: assert property ( // RULE15
		clkEn && wrB |=> jogSpeed == $past(objWrData[6:5])
	) else $error("jog speed wrong");

	// user outputs copy the written word
	AST_USER_BITS: assert property ( // RULE16
		clkEn && wrUser |=> userOut == $past(objWrData)
	) else $error("user outputs wrong");

	// actual mode moves only with permission, and only to the request
	AST_MODE_SWITCH: assert property ( // RULE17
		actualMode != $past(actualMode)
		|-> $past(modeChangeOk) && actualMode == $past(reqMode)
	) else $error("mode changed without permission");

	// demand is nonzero only in current mode
	AST_CURRENT_ONLY: assert property ( // RULE19
		currentDemand != 16'h0000 |-> actualMode == `SDC_MODE_CURRENT
	) else $error("current demand outside current mode");

	// a read is answered on the next cycle
	AST_READ_ANSWER: assert property (
		clkEn && objRdEn |=> objRdValid
	) else $error("read not answered");

	// main scenarios
	COV_CAPTURE_CYCLE: cover property (
		captureArm[2] ##[1:20] captureDisarm[2]
	);
	COV_MODE_CURRENT: cover property (
		actualMode == `SDC_MODE_CURRENT && currentDemand != 16'h0000
	);
	COV_JOG: cover property (jogPlus && jogSpeed == 2'b11);
	COV_BAD_INDEX: cover property (objErr);

endmodule

// file: core/sdc_defs.svh
// constants for the servo drive command word bank
//------------------------------------------------------------------
// Notes on behaviour
// RULE1 - word A bit 0 disables the power bridge
// RULE2 - word A bit 1 zeroes position error
// RULE3 - word A bit 2 starts phase detection
// RULE4 - word A bit 3 loads preset position
// RULE5 - word A bit 4 loads auxiliary command counter
// RULE6 - word A bit 5 keeps homing active
// RULE7 - word A bit 6 commands a stop
// RULE8 - bits 7..9 edges arm/disarm capture units
// RULE9 - word A bit 12 clears most latched events
// RULE10 - reserved bits read zero, written zero
// RULE11 - word B bit 0 edges pick gain set
// RULE12 - word B bit 1 edges pick limiter set
// RULE13 - word B bit 2 edges pick modifier set
// RULE14 - word B bits 3,4 are jog levels
// RULE15 - word B bits 5,6 drive jog speed
// RULE16 - user word bits drive user outputs
// RULE17 - requested mode stored, actual switches when allowed
// RULE18 - fixed operating mode code values
// RULE19 - target current used only in current mode
// RULE20 - word A read/write, up to 1FFFh, volatile
// RULE21 - edges compare new write with stored bit
//------------------------------------------------------------------
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// object indices
`define SDC_IDX_CMD_A        16'h0001
`define SDC_IDX_CMD_B        16'h0002
`define SDC_IDX_USER         16'h0003
`define SDC_IDX_REQ_MODE     16'h0391
`define SDC_IDX_ACT_MODE     16'h0392
`define SDC_IDX_TARGET_CUR   16'h039b

// writable bit masks, reserved bits cleared
`define SDC_MASK_CMD_A       16'h1fff
`define SDC_MASK_CMD_B       16'h007f

// word A field positions
`define SDC_A_BRIDGE_OFF     0
`define SDC_A_ZERO_PERR      1
`define SDC_A_PHASE_DET      2
`define SDC_A_SET_POS        3
`define SDC_A_LOAD_AUX       4
`define SDC_A_HOME_EXEC      5
`define SDC_A_STOP           6
`define SDC_A_CAPTURE_LO     7
`define SDC_A_CAPTURE_HI     9
`define SDC_A_POS_LIMIT      10
`define SDC_A_NEG_LIMIT      11
`define SDC_A_CLEAR_EVENTS   12

// word B field positions
`define SDC_B_SET_LO         0
`define SDC_B_SET_HI         2
`define SDC_B_JOG_PLUS       3
`define SDC_B_JOG_MINUS      4
`define SDC_B_JOG_SPD_LO     5
`define SDC_B_JOG_SPD_HI     6

// operating mode codes
`define SDC_MODE_PROF_POS    8'h01
`define SDC_MODE_PROF_VEL    8'h03
`define SDC_MODE_CURRENT     8'h04
`define SDC_MODE_HOMING      8'h06
`define SDC_MODE_INTERP      8'h07
`define SDC_MODE_JOG         8'h8c
`define SDC_MODE_CONFIG0     8'h9e
`define SDC_MODE_CONFIG1     8'hde
`define SDC_MODE_ENGINE      8'hec
`define SDC_MODE_KEEP        8'hff

// reset values
`define SDC_RST_WORD         16'h0000
`define SDC_RST_MODE         8'hff

`endif

// file: core/sdc_pkg.sv
// types shared by the command word bank
package sdc_pkg;

	// complete state of the bank
	typedef struct packed {
		logic [15:0] cmdA;
		logic [15:0] cmdB;
		logic [15:0] userBits;
		logic [7:0]  reqMode;
		logic [7:0]  actMode;
		logic [15:0] targetCur;
		logic [15:0] currentDemand;
		logic [2:0]  captureArm;
		logic [2:0]  captureDisarm;
		logic [2:0]  setSelect;
		logic [15:0] rdData;
		logic        rdValid;
		logic        accErr;
	} sdc_state_t;

endpackage

// file: core/sdc_edge_det.sv
// rise and fall detector between stored and written bits
`timescale 1ns/1ps

module sdc_edge_det #(
	parameter int W = 3
) (
	input  wire logic [W-1:0] prevBits,
	input  wire logic [W-1:0] newBits,
	input  wire logic         wrStrobe,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	// only a real write can make an edge; rewriting the same value is quiet
	always_comb begin
		rise = wrStrobe ? (newBits & ~prevBits) : '0; // RULE21
		fall = wrStrobe ? (~newBits & prevBits) : '0; // RULE21
	end

endmodule

// file: verification/sdc_master_model.sv
// network master model: issues single object writes and reads
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdc_master_model (
	input  wire logic        ref_clk,
	output logic             objWrEn,
	output logic             objRdEn,
	output logic      [15:0] objIndex,
	output logic      [15:0] objWrData
);
	//------------------------------------------------------------
	// request drivers
	//------------------------------------------------------------
	// idle until the first task call
	initial begin
		objWrEn = 1'b0;
		objRdEn = 1'b0;
		objIndex = 16'h0000;
		objWrData = 16'h0000;
	end

	// writable bits of each object
	function automatic logic [15:0] wmask(input logic [15:0] idx);
		if (idx == `SDC_IDX_CMD_A)
			return `SDC_MASK_CMD_A;
		if (idx == `SDC_IDX_CMD_B)
			return `SDC_MASK_CMD_B;
		return 16'hffff;
	endfunction

	// one write cycle; raw keeps reserved bits set on purpose
	task automatic wr(input logic [15:0] idx, input logic [15:0] d,
		input bit raw);
		@(posedge ref_clk);
		objWrEn <= 1'b1;
		objIndex <= idx;
		objWrData <= raw ? d : (d & wmask(idx));
		@(posedge ref_clk);
		objWrEn <= 1'b0;
		// stale data is inverted so nothing relies on it
		objWrData <= ~d;
	endtask

	// one read cycle; answer is sampled by the caller
	task automatic rd(input logic [15:0] idx);
		@(posedge ref_clk);
		objRdEn <= 1'b1;
		objIndex <= idx;
		@(posedge ref_clk);
		objRdEn <= 1'b0;
		objIndex <= ~idx;
	endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the command word bank
`timescale 1ns/1ps
`include "sdc_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	fail_count++; $display("unexpected %s exp %h got %h", nm, ex, got); \
	end end

module tb;
	logic        ref_clk, rst_b, clkEn, modeChangeOk;
	logic        objWrEn, objRdEn, objRdValid, objErr;
	logic [15:0] objIndex, objWrData, objRdData;
	logic        bridgeDisable, zeroPosError, phaseDetect, setPosition;
	logic        loadAuxCounter, homeExecute, cmdStop, posLimit, negLimit;
	logic        clearEvents, gainSet, limiterSet, modifierSet;
	logic        jogPlus, jogMinus;
	logic [2:0]  captureArm, captureDisarm;
	logic [1:0]  jogSpeed;
	logic [15:0] userOut, currentDemand, prevA, d, cur;
	logic [7:0]  reqMode, actualMode;
	logic [7:0]  modes [10];
	logic [31:0] seed;
	int          fail_count, cmp_count;

	sdc_master_model m (.ref_clk, .objWrEn, .objRdEn, .objIndex,
		.objWrData);

	sdc_command_bank dut (.ref_clk, .rst_b, .clkEn, .objWrEn, .objRdEn,
		.objIndex, .objWrData, .objRdData, .objRdValid, .objErr,
		.modeChangeOk, .bridgeDisable, .zeroPosError, .phaseDetect,
		.setPosition, .loadAuxCounter, .homeExecute, .cmdStop,
		.captureArm, .captureDisarm, .posLimit, .negLimit, .clearEvents,
		.gainSet, .limiterSet, .modifierSet, .jogPlus, .jogMinus,
		.jogSpeed, .userOut, .reqMode, .actualMode, .currentDemand);

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	// free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// sixteen lfsr steps so successive values share little
	function automatic logic [15:0] rnd();
		for (int i = 0; i < 16; i++)
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[15:0];
	endfunction

	// demand only follows the target in current mode
	function automatic logic [15:0] exp_dem(input logic [7:0] mo,
		input logic [15:0] c);
		return (mo == `SDC_MODE_CURRENT) ? c : 16'h0000;
	endfunction

	// verdict, reached from the sequence and the watchdog
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog: the whole run needs well under 2000 cycles
	initial begin
		repeat (2000) @(posedge ref_clk);
		fail_count++;
		test_done();
	end

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		modeChangeOk = 1'b0;
		seed = 32'h5860;
		prevA = 16'h0000;
		fail_count = 0;
		cmp_count = 0;
		// current mode last, so a refused switch keeps it
		modes = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h8c, 8'h9e, 8'hde, 8'hec,
			8'hff, 8'h04};
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		#1;
		`CHK("actualMode", 8'hff, actualMode)
		`CHK("userOut", 16'h0000, userOut)
		$display("test reset done");
		// word A: random, one repeated value, one with reserved bits
		for (int i = 0; i < 24; i++) begin
			d = (i == 23) ? 16'hffff : ((i == 10) ? prevA : rnd());
			m.wr(`SDC_IDX_CMD_A, d, i == 23);
			#1;
			`CHK("wordA", {d[12:10], d[6:0]}, {clearEvents, negLimit,
				posLimit, cmdStop, homeExecute, loadAuxCounter, setPosition,
				phaseDetect, zeroPosError, bridgeDisable})
			`CHK("arm", d[9:7] & ~prevA[9:7], captureArm)
			`CHK("disarm", ~d[9:7] & prevA[9:7], captureDisarm)
			m.rd(`SDC_IDX_CMD_A);
			#1;
			`CHK("rdValid", 1'b1, objRdValid)
			`CHK("rdA", d & 16'h1fff, objRdData)
			prevA = d & 16'h1fff;
		end
		$display("test word A done");
		// word B and user bits
		for (int i = 0; i < 12; i++) begin
			d = (i == 11) ? 16'hffff : rnd();
			m.wr(`SDC_IDX_CMD_B, d, i == 11);
			#1;
			`CHK("wordB", d[6:0], {jogSpeed, jogMinus, jogPlus,
				modifierSet, limiterSet, gainSet})
			m.rd(`SDC_IDX_CMD_B);
			#1;
			`CHK("rdB", d & 16'h007f, objRdData)
			m.wr(`SDC_IDX_USER, ~d, 1'b0);
			#1;
			`CHK("userOut", ~d, userOut)
		end
		$display("test word B and user done");
		// every mode code with switching allowed
		cur = rnd();
		m.wr(`SDC_IDX_TARGET_CUR, cur, 1'b0);
		modeChangeOk <= 1'b1;
		foreach (modes[i]) begin
			m.wr(`SDC_IDX_REQ_MODE, {8'h00, modes[i]}, 1'b0);
			#1;
			`CHK("reqMode", modes[i], reqMode)
			@(posedge ref_clk);
			#1;
			`CHK("actualMode", modes[i], actualMode)
			`CHK("demand", exp_dem(modes[i], cur), currentDemand)
		end
		// switch refused: actual mode and demand must hold
		@(posedge ref_clk);
		modeChangeOk <= 1'b0;
		m.wr(`SDC_IDX_REQ_MODE, 16'h0001, 1'b0);
		@(posedge ref_clk);
		#1;
		`CHK("reqMode", 8'h01, reqMode)
		`CHK("actualMode", 8'h04, actualMode)
		`CHK("demand", cur, currentDemand)
		// read-only actual mode and an unmapped index
		m.wr(`SDC_IDX_ACT_MODE, 16'h0001, 1'b0);
		#1;
		`CHK("wrErr", 1'b1, objErr)
		m.rd(16'h0555);
		#1;
		`CHK("rdErr", 1'b1, objErr)
		`CHK("rdUnk", 16'h0000, objRdData)
		`CHK("actualMode", 8'h04, actualMode)
		$display("test modes done");
		// enable low: a write and a read must both be ignored
		@(posedge ref_clk);
		clkEn <= 1'b0;
		m.wr(`SDC_IDX_USER, rnd(), 1'b0);
		#1;
		`CHK("userFrozen", ~d, userOut)
		m.rd(`SDC_IDX_CMD_A);
		#1;
		`CHK("rdFrozen", 1'b0, objRdValid)
		@(posedge ref_clk);
		clkEn <= 1'b1;
		m.rd(`SDC_IDX_USER);
		#1;
		`CHK("rdUser", ~d, objRdData)
		$display("test enable done");
		test_done();
	end
endmodule
